// *** core/bto_pkg.sv ***
// Shared constants for the bridge transaction ordering block.
// Assumes one clock; all users import the whole package.

package bto_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int DATA_W     = 32;
  localparam int FIFO_DEPTH = 16;
  // Ordering stamp width; must exceed twice the outstanding writes
  localparam int CNT_W      = 8;

  // ****************************************************************
  // Direction indices
  // ****************************************************************
  localparam int DIR_DOWN = 0;
  localparam int DIR_UP   = 1;
  localparam int NUM_DIR  = 2;

  // ****************************************************************
  // Kind codes shown on the master port
  // ****************************************************************
  localparam int          KIND_W     = 3;
  localparam logic [2:0]  KIND_PW    = 3'h0;
  localparam logic [2:0]  KIND_DRD   = 3'h1;
  localparam logic [2:0]  KIND_DWR   = 3'h2;
  localparam logic [2:0]  KIND_CRD   = 3'h3;
  localparam logic [2:0]  KIND_CWR   = 3'h4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;

endpackage : bto_pkg

// *** core/bto_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.

`timescale 1ns/100ps

module bto_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  import bto_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic [AW:0]  used;
  logic         push;
  logic         pop;

  // Extra pointer bit tells full from empty without a counter
  assign used        = wr_ptr - rd_ptr;
  assign in_ready_o  = (used != DEPTH[AW:0]);
  assign out_valid_o = (used != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'h1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'h1;
      end
    end
  end

endmodule // bto_fifo

// *** core/bto_top.sv ***
// Transaction ordering engine for a PCI-to-PCI bridge, both directions.
// Assumes its queue inputs and master port come from bus logic on the
// same PCI clock, so no input is synchronised.
//
// Notes on behaviour
// - Posted writes leave in the exact order they were accepted.
// - A delayed read request waits for every earlier posted write.
// - Read completion data waits for every earlier posted write.
// - A delayed write request never passes an earlier posted write.
// - Posted writes may pass any queued delayed request or completion.
// - A fair alternation picks between posted and delayed queues.
// - Order holds per direction; completions run opposite requests.
// - No buffer flush or interrupt hold-back syncs data delivery.
// - Retried delayed requests may be taken in any order but finish in queue order.
// - Posted writes enter both directions at once, unordered.
// - Taking a posted write never waits on any delayed transaction.

`timescale 1ns/100ps

module bto_top #(
  parameter int DW    = bto_pkg::DATA_W,
  parameter int DEPTH = bto_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                               sys_clk_i,
  input  wire logic                               rst_i,
  // Posted writes taken as target, one lane per direction
  input  wire logic [bto_pkg::NUM_DIR-1:0]        pw_valid_i,
  output logic      [bto_pkg::NUM_DIR-1:0]        pw_ready_o,
  input  wire logic [bto_pkg::NUM_DIR-1:0][DW-1:0] pw_data_i,
  // Delayed requests queued after target retry
  input  wire logic [bto_pkg::NUM_DIR-1:0]        dreq_valid_i,
  input  wire logic [bto_pkg::NUM_DIR-1:0]        dreq_write_i,
  input  wire logic [bto_pkg::NUM_DIR-1:0][DW-1:0] dreq_data_i,
  output logic      [bto_pkg::NUM_DIR-1:0]        dreq_ready_o,
  // Delayed completions, lane is the direction the data travels
  input  wire logic [bto_pkg::NUM_DIR-1:0]        cpl_valid_i,
  input  wire logic [bto_pkg::NUM_DIR-1:0]        cpl_read_i,
  input  wire logic [bto_pkg::NUM_DIR-1:0][DW-1:0] cpl_data_i,
  output logic      [bto_pkg::NUM_DIR-1:0]        cpl_ready_o,
  // Master side toward the destination bus
  output logic      [bto_pkg::NUM_DIR-1:0]        out_valid_o,
  output logic [bto_pkg::NUM_DIR-1:0][bto_pkg::KIND_W-1:0] out_kind_o,
  output logic      [bto_pkg::NUM_DIR-1:0][DW-1:0] out_data_o,
  input  wire logic [bto_pkg::NUM_DIR-1:0]        out_ready_i
);

  import bto_pkg::*;

  // Stamped entry: {flag, stamp, data}
  localparam int SW = DW + CNT_W + 1;

  // ****************************************************************
  // One independent ordering lane per direction
  // ****************************************************************
  // Lanes share nothing, so writes in opposite directions never wait
  // on each other and both may be accepted in the same cycle
  for (genvar d = 0; d < NUM_DIR; d++) begin : g_dir

    // **************************************************************
    // Lane signals
    // **************************************************************
    logic [CNT_W-1:0]  pw_acc;
    logic [CNT_W-1:0]  pw_done;
    logic              pf_v;
    logic              pf_r;
    logic [DW-1:0]     pf_d;
    logic              rq_v;
    logic              rq_r;
    logic [SW-1:0]     rq_d;
    logic              cp_v;
    logic              cp_r;
    logic [SW-1:0]     cp_d;
    logic              pw_push;
    logic              rq_is_wr;
    logic [CNT_W-1:0]  rq_diff;
    logic              rq_ok;
    logic              cp_is_rd;
    logic [CNT_W-1:0]  cp_diff;
    logic              cp_ok;
    logic              dl_ok;
    logic              load;
    logic              pick_pw;
    logic              pick_dl;
    logic              pw_retire;
    logic              turn_dl;
    logic              ov;
    logic [KIND_W-1:0] okind;
    logic [DW-1:0]     odata;
    logic [KIND_W-1:0] next_kind;
    logic [DW-1:0]     next_data;

    // **************************************************************
    // Queues
    // **************************************************************
    // Posted queue ready depends only on its own room
    bto_fifo #(
      .W     (DW),
      .DEPTH (DEPTH)
    ) u_pw_q (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (pw_valid_i[d]),
      .in_ready_o  (pw_ready_o[d]),
      .in_data_i   (pw_data_i[d]),
      .out_valid_o (pf_v),
      .out_ready_i (pf_r),
      .out_data_o  (pf_d)
    );

    // Each request carries the count of posted writes taken before it
    bto_fifo #(
      .W     (SW),
      .DEPTH (DEPTH)
    ) u_rq_q (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (dreq_valid_i[d]),
      .in_ready_o  (dreq_ready_o[d]),
      .in_data_i   ({dreq_write_i[d], pw_acc, dreq_data_i[d]}),
      .out_valid_o (rq_v),
      .out_ready_i (rq_r),
      .out_data_o  (rq_d)
    );

    // Completions are stamped against writes in the lane they travel
    bto_fifo #(
      .W     (SW),
      .DEPTH (DEPTH)
    ) u_cp_q (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (cpl_valid_i[d]),
      .in_ready_o  (cpl_ready_o[d]),
      .in_data_i   ({cpl_read_i[d], pw_acc, cpl_data_i[d]}),
      .out_valid_o (cp_v),
      .out_ready_i (cp_r),
      .out_data_o  (cp_d)
    );

    // **************************************************************
    // Ordering checks
    // **************************************************************
    // A stamp is cleared once the retired count has caught up with it;
    // sign of the modular difference avoids wrap trouble
    assign pw_push   = pw_valid_i[d] && pw_ready_o[d];
    assign rq_is_wr  = rq_d[SW-1];
    assign rq_diff   = pw_done - rq_d[DW +: CNT_W];
    // Read and write requests both wait for earlier posted writes
    assign rq_ok     = rq_v && !rq_diff[CNT_W-1];
    assign cp_is_rd  = cp_d[SW-1];
    assign cp_diff   = pw_done - cp_d[DW +: CNT_W];
    // Write completions carry no data, so they skip the wait
    assign cp_ok     = cp_v &&
                       (!cp_is_rd || !cp_diff[CNT_W-1]);
    // Request queue is strict order; requests accepted in any retry
    // order upstream are simply queued as they arrive
    assign dl_ok     = cp_ok || rq_ok;

    // **************************************************************
    // Arbitration between posted and delayed queues
    // **************************************************************
    assign load      = !ov || out_ready_i[d];
    // Posted writes never wait on a blocked delayed head
    assign pick_pw   = pf_v && (!dl_ok || !turn_dl);
    assign pick_dl   = dl_ok && (!pf_v || turn_dl);
    assign pf_r      = load && pick_pw;
    // Completion wins over a request inside the delayed side
    assign cp_r      = load && pick_dl && cp_ok;
    assign rq_r      = load && pick_dl && !cp_ok;
    assign next_kind = pick_pw ? KIND_PW :
                       cp_ok   ? (cp_is_rd ? KIND_CRD : KIND_CWR) :
                                 (rq_is_wr ? KIND_DWR : KIND_DRD);
    assign next_data = pick_pw ? pf_d :
                       cp_ok   ? cp_d[DW-1:0] : rq_d[DW-1:0];
    // A posted write is complete when the target takes it
    assign pw_retire = ov && out_ready_i[d] && (okind == KIND_PW);

    // **************************************************************
    // Counters and turn flag
    // **************************************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        pw_acc  <= CNT_RST;
        pw_done <= CNT_RST;
        turn_dl <= 1'h0;
      end else begin
        if (pw_push) begin
          pw_acc <= pw_acc + 1'h1;
        end
        if (pw_retire) begin
          pw_done <= pw_done + 1'h1;
        end
        // Turn changes only when both sides actually competed
        if (load && pf_v && dl_ok) begin
          turn_dl <= pick_pw;
        end
      end
    end

    // **************************************************************
    // Master output stage
    // **************************************************************
    // Registered stage costs one cycle but keeps data off the queues'
    // read mux; nothing here flushes or gates interrupts
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        ov    <= 1'h0;
        okind <= KIND_PW;
        odata <= '0;
      end else if (load) begin
        ov <= pick_pw || pick_dl;
        if (pick_pw || pick_dl) begin
          okind <= next_kind;
          odata <= next_data;
        end
      end
    end

    assign out_valid_o[d] = ov;
    assign out_kind_o[d]  = okind;
    assign out_data_o[d]  = odata;

  end : g_dir

endmodule // bto_top

// *** tb/bto_asserts.sv ***
// Checker for bto_top: output hold, latency and queue room relations.
// Assumes the single clock sys_clk_i and active-high async rst_i.
`timescale 1ns/100ps
module bto_asserts
  import bto_pkg::*;
#(
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic                             sys_clk_i,
  input wire logic                             rst_i,
  // Posted lanes
  input wire logic [bto_pkg::NUM_DIR-1:0]      pw_valid_i,
  input wire logic [bto_pkg::NUM_DIR-1:0]      pw_ready_o,
  // Master port
  input wire logic [bto_pkg::NUM_DIR-1:0]      out_valid_o,
  input wire logic [1:0][bto_pkg::KIND_W-1:0]  out_kind_o,
  input wire logic [1:0][DW-1:0]               out_data_o,
  input wire logic [bto_pkg::NUM_DIR-1:0]      out_ready_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Posted writes held per lane; the fifo can fill only at 16 or more of them
  logic [5:0] pc [2];
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc <= '{6'h00, 6'h00};
    end else begin
      for (int d = 0; d < 2; d++) begin
        pc[d] <= pc[d] + 6'(pw_valid_i[d] & pw_ready_o[d])
          - 6'(out_valid_o[d] & out_ready_i[d] & out_kind_o[d] == KIND_PW);
      end
    end
  end
  a_hold_down: assert property (
    out_valid_o[0] && !out_ready_i[0] |=> out_valid_o[0]
      && $stable(out_data_o[0]) && $stable(out_kind_o[0]))
    else $error("lane 0 output changed before it was taken");
  a_hold_up: assert property (
    out_valid_o[1] && !out_ready_i[1] |=>
      $stable({out_valid_o[1], out_kind_o[1], out_data_o[1]}))
    else $error("lane 1 output changed before it was taken");
  a_kind_legal: assert property (
    out_valid_o[1] |-> out_kind_o[1] <= KIND_CWR)
    else $error("lane 1 shows an unknown kind code");
  a_room_down: assert property (
    !pw_ready_o[0] |-> pc[0] >= 6'h10)
    else $error("lane 0 posted write refused with room left");
  a_room_up: assert property (
    !pw_ready_o[1] |-> pc[1] >= 6'h10)
    else $error("lane 1 posted write refused with room left");
  a_pw_cause: assert property (
    out_valid_o[0] && out_kind_o[0] == KIND_PW |-> pc[0] != 6'h00)
    else $error("posted write shown with none accepted");
  a_reset_idle: assert property (
    $fell(rst_i) |-> out_valid_o == 2'h0)
    else $error("output valid right after reset");
  a_pw_latency: assert property (
    pw_valid_i[1] && pw_ready_o[1] && !out_valid_o[1]
      |-> ##[1:2] out_valid_o[1])
    else $error("idle lane 1 did not present a new posted write");
endmodule // bto_asserts

bind bto_top bto_asserts #(.DW(DW)) i_bto_asserts (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .pw_valid_i(pw_valid_i), .pw_ready_o(pw_ready_o),
  .out_valid_o(out_valid_o), .out_kind_o(out_kind_o),
  .out_data_o(out_data_o), .out_ready_i(out_ready_i));

// *** tb/bto_dest_model.sv ***
// Far-side target model: takes transactions promptly, slowly or not.
// Assumes hold and slow controls come from the testbench.
`timescale 1ns/100ps
module bto_dest_model (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Controls per lane
  input  wire logic [1:0] hold_i,
  input  wire logic [1:0] slow_i,
  // Take strobe toward the master port
  output logic      [1:0] take_o
);
  logic [1:0] ph;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) ph <= 2'h0;
    else ph <= ~ph;
  end
  // Slow mode takes every other cycle
  assign take_o = ~hold_i & (~slow_i | ph);
endmodule // bto_dest_model

// *** tb/tb_top.sv ***
// Testbench for bto_top: queue drivers, far-side model and checks.
// Assumes bto_pkg, the core files, bto_dest_model and the checker.
`timescale 1ns/100ps
module tb_top;
  import bto_pkg::*;
  // ****************
  // Signals
  // ****************
  logic             sys_clk_i, rst_i;
  logic [1:0]       pw_valid_i, pw_ready_o, dreq_valid_i, dreq_write_i;
  logic [1:0]       dreq_ready_o, cpl_valid_i, cpl_read_i, cpl_ready_o;
  logic [1:0]       out_valid_o, out_ready_i, hold, slow;
  logic [1:0][31:0] pw_data_i, dreq_data_i, cpl_data_i, out_data_o;
  logic [1:0][2:0]  out_kind_o;
  logic [34:0]      got [2][$];
  int               failures, checked;
  bto_top i_bto_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .pw_valid_i(pw_valid_i), .pw_ready_o(pw_ready_o), .pw_data_i(pw_data_i),
    .dreq_valid_i(dreq_valid_i), .dreq_write_i(dreq_write_i),
    .dreq_data_i(dreq_data_i), .dreq_ready_o(dreq_ready_o),
    .cpl_valid_i(cpl_valid_i), .cpl_read_i(cpl_read_i),
    .cpl_data_i(cpl_data_i), .cpl_ready_o(cpl_ready_o),
    .out_valid_o(out_valid_o), .out_kind_o(out_kind_o),
    .out_data_o(out_data_o), .out_ready_i(out_ready_i));
  bto_dest_model i_bto_dest_model (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .hold_i(hold), .slow_i(slow), .take_o(out_ready_i));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  // Kind code k equals the master port code; valid held until taken
  task automatic push(input int k, input int d, input logic [31:0] v);
    int n;
    n = 0;
    case (k)
      0: begin
        pw_valid_i[d] <= 1'h1;
        pw_data_i[d] <= v;
      end
      1, 2: begin
        dreq_valid_i[d] <= 1'h1;
        dreq_write_i[d] <= (k == 2);
        dreq_data_i[d] <= v;
      end
      default: begin
        cpl_valid_i[d] <= 1'h1;
        cpl_read_i[d] <= (k == 3);
        cpl_data_i[d] <= v;
      end
    endcase
    @(negedge sys_clk_i);
    while (!(k == 0 ? pw_ready_o[d] : k < 3 ? dreq_ready_o[d]
             : cpl_ready_o[d]) && n < 99) begin
      n++;
      @(negedge sys_clk_i);
    end
    if (n == 99) failures++;
    @(posedge sys_clk_i);
    pw_valid_i[d] <= 1'h0;
    dreq_valid_i[d] <= 1'h0;
    cpl_valid_i[d] <= 1'h0;
    @(posedge sys_clk_i);
  endtask
  task automatic fill(input int k, output int n);
    n = 0;
    while (n < 20) begin
      @(negedge sys_clk_i);
      if (!(k == 0 ? pw_ready_o[0] : dreq_ready_o[0])) break;
      @(posedge sys_clk_i);
      push(k, 0, n);
      n++;
    end
  endtask
  task automatic t_order();
    logic [34:0] exp [6];
    exp = '{{KIND_PW, 32'h0}, {KIND_PW, 32'h1}, {KIND_PW, 32'h2},
      {KIND_CRD, 32'h12}, {KIND_DRD, 32'h10}, {KIND_DWR, 32'h11}};
    got[0] = {};
    got[1] = {};
    hold <= 2'h1;
    for (int i = 0; i < 3; i++) fork
      push(0, 0, i);
      push(0, 1, i + 8);
    join
    push(1, 0, 32'h10);
    push(2, 0, 32'h11);
    // Read back along the written path
    push(3, 0, 32'h12);
    push(3, 1, 32'h13);
    repeat (8) @(posedge sys_clk_i);
    chk(35'(got[0].size()), 35'h0);
    for (int i = 0; i < 3; i++)
      chk(got[1][i], {KIND_PW, 32'(i + 8)});
    chk(got[1][3], {KIND_CRD, 32'h13});
    hold <= 2'h0;
    slow <= 2'h1;
    repeat (30) @(posedge sys_clk_i);
    slow <= 2'h0;
    chk(35'(got[0].size()), 35'h6);
    for (int i = 0; i < 6; i++)
      chk(got[0][i], exp[i]);
    $display("test order done");
  endtask
  task automatic t_pass(input int f, input int l);
    int p;
    p = 9;
    got[0] = {};
    hold <= 2'h1;
    for (int i = 0; i < 3; i++) push(f, 0, i);
    push(l, 0, 32'h20);
    hold <= 2'h0;
    repeat (20) @(posedge sys_clk_i);
    foreach (got[0][i]) if (got[0][i][31:0] == 32'h20) p = i;
    chk(35'(got[0].size()), 35'h4);
    chk(35'(p < 3), 35'h1);
    $display("test pass %0d %0d done", f, l);
  endtask
  task automatic t_fill();
    int n;
    got[0] = {};
    hold <= 2'h1;
    fill(1, n);
    chk(35'(n), 35'h11);
    chk(35'(pw_ready_o[0]), 35'h1);
    fill(0, n);
    chk(35'(n), 35'h10);
    @(posedge sys_clk_i);
    hold <= 2'h0;
    slow <= 2'h1;
    repeat (100) @(posedge sys_clk_i);
    chk(35'(got[0].size()), 35'h21);
    $display("test fill done");
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****************
  // Processes
  // ****************
  always @(negedge sys_clk_i) begin
    for (int d = 0; d < 2; d++)
      if (out_valid_o[d] && out_ready_i[d])
        got[d].push_back({out_kind_o[d], out_data_o[d]});
  end
  initial begin
    sys_clk_i = 1'h0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #400000;
    failures++;
    end_sim();
  end
  initial begin
    {rst_i, hold, slow} = 5'h10;
    {pw_valid_i, dreq_valid_i, dreq_write_i, cpl_valid_i, cpl_read_i} = '0;
    {pw_data_i, dreq_data_i, cpl_data_i} = '0;
    failures = 0;
    checked = 0;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    @(posedge sys_clk_i);
    t_order();
    t_pass(1, 0);
    t_pass(2, 0);
    t_pass(3, 0);
    t_pass(0, 4);
    t_fill();
    end_sim();
  end
endmodule // tb_top
